// [common/vrc_pkg.sv]
// Purpose: constants shared by the regulator configuration register bank
// Assumes: one-byte registers addressed by an eight-bit command code
// Notes: masks list the bits that hold real settings; all others read zero
package vrc_pkg;

  // command codes of the two configuration registers
  localparam logic [7:0] RAIL_CFG_ADDR = 8'h00_D2;
  localparam logic [7:0] PHASE_CFG_ADDR = 8'h00_D3;

  // reset values
  localparam logic [7:0] RAIL_CFG_RST = 8'h00_00;
  localparam logic [7:0] PHASE_CFG_RST = 8'h00_03;

  // writable bit masks
  localparam logic [7:0] RAIL_CFG_MASK = 8'h00_45;
  localparam logic [7:0] PHASE_CFG_MASK = 8'h00_03;

  // rail configuration field positions
  localparam int SRC_DIGITAL_BIT = 0;
  localparam int NB_RAIL_BIT = 2;
  localparam int LATCHOFF_DIS_BIT = 6;

  // phase configuration field positions
  localparam int PS_LEVEL0_BIT = 1;
  localparam int PS_LEVEL1_BIT = 0;

  // number of stages of the pin synchroniser
  localparam int SYNC_STAGES = 3;

  // phase behaviour chosen by the power-state field
  typedef enum logic [1:0] {
    PH_SINGLE_DCM,
    PH_SINGLE_CCM,
    PH_ALL
  } vrc_phase_e;

endpackage : vrc_pkg

// [logic/vrc_phase_decode.sv]
// Purpose: decode the power-state field into a phase behaviour
// Assumes: field bit 1 is level-0 input, bit 0 is level-1 input
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
module vrc_phase_decode (
  // power-state field
  input wire logic powerStateLevel0N,
  input wire logic powerStateLevel1N,
  // decoded behaviour
  output vrc_pkg::vrc_phase_e phaseMode
);

  // level-0 high forces all phases, otherwise level-1 picks the mode
  always_comb begin
    if (powerStateLevel0N) begin
      phaseMode = vrc_pkg::PH_ALL; // RULE_04
    end else if (powerStateLevel1N) begin
      phaseMode = vrc_pkg::PH_SINGLE_CCM; // RULE_04
    end else begin
      phaseMode = vrc_pkg::PH_SINGLE_DCM; // RULE_04
    end
  end

endmodule : vrc_phase_decode

// [logic/vrc_config_regs.sv]
// Purpose: two configuration registers of the regulator controller
// Assumes: the serial transaction layer hands in command code and strobes
// Notes: reads answer one cycle after the strobe, unmapped reads give zero
// What this block does
// (RULE_01) rail bit 0 picks parameter source
// (RULE_02) rail bit 2 picks programmable output rail
// (RULE_03) rail bit 6 suppresses current-limit latch-off
// (RULE_04) phase field 00 DCM, 01 CCM, else all
// (RULE_05) phase resets to 0x03, rail to zero
// (RULE_06) reserved bits read zero, ignore writes
`timescale 1ns/1ps
module vrc_config_regs (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  // register port from the transaction layer
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  input wire logic regRead,
  output logic [7:0] regRdata,
  output logic regAck,
  output logic regErr,
  // current limit comparator pin, asynchronous
  input wire logic currentLimit,
  // configuration outputs
  output logic paramSourceDigital,
  output logic nbRailSelected,
  output logic currentLimitLatchoffDisable,
  output logic regulatorLatchedOff,
  output logic powerStateLevel0N,
  output logic powerStateLevel1N,
  output vrc_pkg::vrc_phase_e phaseMode
);

  // whole state of the block
  typedef struct packed {
    logic [7:0] railCfg;
    logic [7:0] phaseCfg;
    logic [7:0] rdata;
    logic ack;
    logic err;
    logic [vrc_pkg::SYNC_STAGES-1:0] limSync;
    logic limLevel;
    logic latchedOff;
    vrc_pkg::vrc_phase_e phase;
  } vrc_state_s;

  vrc_state_s q;
  vrc_state_s next_q;
  vrc_pkg::vrc_phase_e decodedPhase;

  // true when the command code names a configuration register
  function automatic logic vrc_is_mapped(input logic [7:0] addr);
    vrc_is_mapped = (addr == vrc_pkg::RAIL_CFG_ADDR) ||
                    (addr == vrc_pkg::PHASE_CFG_ADDR);
  endfunction : vrc_is_mapped

  // readback of a register, reserved bits masked to zero
  function automatic logic [7:0] vrc_readback(input logic [7:0] addr,
                                              input logic [7:0] rail,
                                              input logic [7:0] phase);
    vrc_readback = 8'h00_00;
    if (addr == vrc_pkg::RAIL_CFG_ADDR) begin
      vrc_readback = rail & vrc_pkg::RAIL_CFG_MASK; // RULE_06
    end else if (addr == vrc_pkg::PHASE_CFG_ADDR) begin
      vrc_readback = phase & vrc_pkg::PHASE_CFG_MASK; // RULE_06
    end
  endfunction : vrc_readback

  // phase behaviour from the stored power-state field
  vrc_phase_decode u_phase_decode (
    .powerStateLevel0N(q.phaseCfg[vrc_pkg::PS_LEVEL0_BIT]),
    .powerStateLevel1N(q.phaseCfg[vrc_pkg::PS_LEVEL1_BIT]),
    .phaseMode(decodedPhase)
  );

  // next state
  always_comb begin
    next_q = q;
    next_q.ack = 1'b0;
    next_q.err = 1'b0;
    // synchroniser shifts; level moves once last two stages agree
    next_q.limSync = {q.limSync[vrc_pkg::SYNC_STAGES-2:0], currentLimit};
    if (q.limSync[vrc_pkg::SYNC_STAGES-1] ==
        q.limSync[vrc_pkg::SYNC_STAGES-2]) begin
      next_q.limLevel = q.limSync[vrc_pkg::SYNC_STAGES-1];
    end
    // register writes keep only the supported bits
    if (regWrite) begin
      next_q.ack = 1'b1;
      next_q.err = !vrc_is_mapped(regAddr);
      if (regAddr == vrc_pkg::RAIL_CFG_ADDR) begin
        next_q.railCfg = regWdata & vrc_pkg::RAIL_CFG_MASK; // RULE_06
      end else if (regAddr == vrc_pkg::PHASE_CFG_ADDR) begin
        next_q.phaseCfg = regWdata & vrc_pkg::PHASE_CFG_MASK; // RULE_06
      end
    end else if (regRead) begin
      next_q.ack = 1'b1;
      next_q.err = !vrc_is_mapped(regAddr);
      next_q.rdata = vrc_readback(regAddr, q.railCfg, q.phaseCfg);
    end
    // current limit latches off unless suppressed; held until reset
    if (q.limLevel && !q.railCfg[vrc_pkg::LATCHOFF_DIS_BIT]) begin
      next_q.latchedOff = 1'b1; // RULE_03
    end
    next_q.phase = decodedPhase; // RULE_04
  end

  // state register, frozen while the enable is low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q.railCfg <= vrc_pkg::RAIL_CFG_RST; // RULE_05
      q.phaseCfg <= vrc_pkg::PHASE_CFG_RST; // RULE_05
      q.rdata <= 8'h00_00;
      q.ack <= 1'b0;
      q.err <= 1'b0;
      q.limSync <= '0;
      q.limLevel <= 1'b0;
      q.latchedOff <= 1'b0;
      q.phase <= vrc_pkg::PH_ALL;
    end else if (clkEn) begin
      q <= next_q;
    end
  end

  // outputs straight from the state
  assign regRdata = q.rdata;
  assign regAck = q.ack;
  assign regErr = q.err;
  assign paramSourceDigital = q.railCfg[vrc_pkg::SRC_DIGITAL_BIT]; // RULE_01
  assign nbRailSelected = q.railCfg[vrc_pkg::NB_RAIL_BIT]; // RULE_02
  assign currentLimitLatchoffDisable =
    q.railCfg[vrc_pkg::LATCHOFF_DIS_BIT]; // RULE_03
  assign regulatorLatchedOff = q.latchedOff;
  assign powerStateLevel0N = q.phaseCfg[vrc_pkg::PS_LEVEL0_BIT];
  assign powerStateLevel1N = q.phaseCfg[vrc_pkg::PS_LEVEL1_BIT];
  assign phaseMode = q.phase;

  // helper: low from reset until the first enabled clock edge
  logic seenEdge;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      seenEdge <= 1'b0;
    end else if (clkEn) begin
      seenEdge <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // a write to the rail register with enable
  sequence s_rail_write;
    regWrite && clkEn && regAddr == vrc_pkg::RAIL_CFG_ADDR;
  endsequence

  // a write to the phase register with enable
  sequence s_phase_write;
    regWrite && clkEn && regAddr == vrc_pkg::PHASE_CFG_ADDR;
  endsequence

  // source select follows written bit 0
  a_source_select: assert property ( // RULE_01
    s_rail_write |=>
      paramSourceDigital == $past(regWdata[vrc_pkg::SRC_DIGITAL_BIT]))
    else $error("source select did not follow write");

  // rail select follows written bit 2
  a_rail_select: assert property ( // RULE_02
    s_rail_write |=>
      nbRailSelected == $past(regWdata[vrc_pkg::NB_RAIL_BIT]))
    else $error("rail select did not follow write");

  // suppressed latch-off never latches from a clean start
  a_latch_suppress: assert property ( // RULE_03
    (currentLimitLatchoffDisable && !regulatorLatchedOff)
      |=> !regulatorLatchedOff)
    else $error("latched off while suppressed");

  // enabled limit latches within one cycle, then holds
  a_latch_set: assert property ( // RULE_03
    (q.limLevel && !currentLimitLatchoffDisable && clkEn)
      |=> regulatorLatchedOff ##1 regulatorLatchedOff)
    else $error("current limit did not latch off");

  // phase decode two cycles after a write
  a_phase_decode: assert property ( // RULE_04
    s_phase_write ##1 clkEn |=>
      phaseMode == ($past(regWdata[vrc_pkg::PS_LEVEL0_BIT], 2) ?
                    vrc_pkg::PH_ALL :
                    $past(regWdata[vrc_pkg::PS_LEVEL1_BIT], 2) ?
                    vrc_pkg::PH_SINGLE_CCM :
                    vrc_pkg::PH_SINGLE_DCM))
    else $error("phase mode wrong after write");

  // reset values seen in the first cycle
  a_reset_values: assert property ( // RULE_05
    !seenEdge |-> q.phaseCfg == vrc_pkg::PHASE_CFG_RST &&
                  q.railCfg == vrc_pkg::RAIL_CFG_RST)
    else $error("reset values wrong");

  // reserved bits never set
  a_reserved_zero: assert property ( // RULE_06
    (q.railCfg & ~vrc_pkg::RAIL_CFG_MASK) == 8'h00_00 &&
    (q.phaseCfg & ~vrc_pkg::PHASE_CFG_MASK) == 8'h00_00)
    else $error("reserved bit set");

  // readback of phase register masks upper bits
  a_read_masked: assert property ( // RULE_06
    (regRead && !regWrite && clkEn && regAddr == vrc_pkg::PHASE_CFG_ADDR)
      |=> regAck && regRdata[7:2] == 6'h00)
    else $error("reserved read back nonzero");

  // readback of rail register masks reserved bits
  a_read_rail_masked: assert property ( // RULE_06
    (regRead && !regWrite && clkEn && regAddr == vrc_pkg::RAIL_CFG_ADDR)
      |=> regAck && (regRdata & ~vrc_pkg::RAIL_CFG_MASK) == 8'h00_00)
    else $error("reserved rail bit read back");

  // unmapped write flags an error and leaves both registers alone
  a_unmapped_keep: assert property ( // RULE_06
    (regWrite && clkEn && !vrc_is_mapped(regAddr))
      |=> regErr && $stable(q.railCfg) && $stable(q.phaseCfg))
    else $error("unmapped write disturbed a register");

  // latch-off holds until reset
  a_latch_sticky: assert property ( // RULE_03
    regulatorLatchedOff |=> regulatorLatchedOff)
    else $error("latch-off released without reset");

endmodule : vrc_config_regs

// [test/vrc_host_model.sv]
// Purpose: host side model issuing single-byte register accesses
// Assumes: strobes are taken at a rising clk_sys, answer one cycle on
// Notes: released address and data lines show inverted values
`timescale 1ns/1ps
module vrc_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic [7:0] regWdata,
  output logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic regAck,
  input wire logic regErr
);
  // idle bus at time zero
  initial begin
    regAddr = 8'h00_00;
    regWrite = 1'b0;
    regWdata = 8'h00_00;
    regRead = 1'b0;
  end

  // one strobe cycle, then release and take the answer at the next edge
  task automatic access(input logic wr, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic ok,
    output logic e);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= wr;
    regRead <= !wr;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    regAddr <= ~a; // no stale address after release
    regWdata <= ~d;
    @(posedge clk_sys);
    q = regRdata;
    ok = regAck;
    e = regErr;
  endtask : access
endmodule : vrc_host_model

// [test/vrc_config_regs_tb.sv]
// Purpose: self-checking bench for the configuration register bank
// Assumes: clock enable high except in the freeze scenario
// Notes: each scenario task drives and judges its own traffic
`timescale 1ns/1ps
module vrc_config_regs_tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic currentLimit = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr, regWdata, regRdata, q;
  logic regWrite, regRead, regAck, regErr, latched;
  logic paramSourceDigital, nbRailSelected, currentLimitLatchoffDisable;
  logic powerStateLevel0N, powerStateLevel1N;
  vrc_pkg::vrc_phase_e phaseMode;
  int fail_count = 0;
  int n_compared = 0;
  localparam logic [7:0] RAIL = vrc_pkg::RAIL_CFG_ADDR;
  localparam logic [7:0] PHS = vrc_pkg::PHASE_CFG_ADDR;

  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;

  vrc_host_model u_host (.clk_sys(clk_sys), .regAddr(regAddr),
    .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead),
    .regRdata(regRdata), .regAck(regAck), .regErr(regErr));
  vrc_config_regs u_dut (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn),
    .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
    .regRead(regRead), .regRdata(regRdata), .regAck(regAck),
    .regErr(regErr), .currentLimit(currentLimit),
    .paramSourceDigital(paramSourceDigital), .nbRailSelected(nbRailSelected),
    .currentLimitLatchoffDisable(currentLimitLatchoffDisable),
    .regulatorLatchedOff(latched), .powerStateLevel0N(powerStateLevel0N),
    .powerStateLevel1N(powerStateLevel1N), .phaseMode(phaseMode));

  // byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // access with answer checks
  task automatic rw(input logic wr, input logic [7:0] a,
    input logic [7:0] d, input logic e);
    logic ok;
    logic er;
    u_host.access(wr, a, d, q, ok, er);
    chk({7'b0, ok}, 8'h00_01);
    chk({7'b0, er}, {7'b0, e});
  endtask : rw

  // rail outputs packed at their register positions
  task automatic rail_out(input logic [7:0] exp);
    chk({1'b0, currentLimitLatchoffDisable, 3'b0, nbRailSelected, 1'b0,
      paramSourceDigital}, exp);
  endtask : rail_out

  task automatic t_reset;
    rw(0, RAIL, 8'h00_00, 0);
    chk(q, 8'h00_00);
    rw(0, PHS, 8'h00_00, 0);
    chk(q, 8'h00_03);
    rail_out(8'h00_00);
    chk(8'(phaseMode), 8'(vrc_pkg::PH_ALL));
  endtask : t_reset

  task automatic t_rail;
    rw(1, RAIL, 8'h00_FF, 0);
    rail_out(8'h00_45);
    rw(0, RAIL, 8'h00_00, 0);
    chk(q, 8'h00_45);
    rw(1, RAIL, 8'h00_BA, 0);
    rail_out(8'h00_00);
  endtask : t_rail

  // every power-state code, reserved bits set alongside
  task automatic t_phase;
    logic [7:0] m;
    for (int v = 0; v < 4; v++) begin
      m = v == 0 ? 8'(vrc_pkg::PH_SINGLE_DCM) :
        v == 1 ? 8'(vrc_pkg::PH_SINGLE_CCM) : 8'(vrc_pkg::PH_ALL);
      rw(1, PHS, 8'h00_FC | 8'(v), 0);
      rw(0, PHS, 8'h00_00, 0);
      chk(q, 8'(v));
      chk({6'b0, powerStateLevel0N, powerStateLevel1N}, 8'(v));
      chk(8'(phaseMode), m);
    end
  endtask : t_phase

  task automatic t_unmapped;
    rw(1, 8'h00_D1, 8'h00_FF, 1);
    rw(0, 8'h00_D1, 8'h00_00, 1);
    chk(q, 8'h00_00);
  endtask : t_unmapped

  // latch-off suppressed, then armed with the pin still high
  task automatic t_latch;
    rw(1, RAIL, 8'h00_40, 0);
    currentLimit <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk({7'b0, latched}, 8'h00_00);
    rw(1, RAIL, 8'h00_00, 0);
    repeat (8) @(posedge clk_sys);
    chk({7'b0, latched}, 8'h00_01);
  endtask : t_latch

  // strobes with the enable low are neither taken nor answered
  task automatic t_freeze;
    logic ok;
    logic er;
    clkEn <= 1'b0;
    u_host.access(1'b1, RAIL, 8'h00_45, q, ok, er);
    chk({7'b0, ok}, 8'h00_00);
    clkEn <= 1'b1;
    rail_out(8'h00_00);
  endtask : t_freeze

  // reset in mid-run clears the latch and the rail register, and returns phase to 0x03
  task automatic t_rereset;
    currentLimit <= 1'b0;
    rw(1, RAIL, 8'h00_FF, 0);
    rw(1, PHS, 8'h00_00, 0);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    chk({7'b0, latched}, 8'h00_00);
    rail_out(8'h00_00);
    chk(8'(phaseMode), 8'(vrc_pkg::PH_ALL));
    rw(0, PHS, 8'h00_00, 0);
    chk(q, 8'h00_03);
  endtask : t_rereset

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_freeze();
    t_rail();
    t_phase();
    t_unmapped();
    t_latch();
    t_rereset();
    close_out();
  end

  // watchdog
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
endmodule : vrc_config_regs_tb
